// ==== core/dimc_pkg.sv ====
// Shared constants, enumerations and carriers for the drive input macro control block
package dimc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int DEBOUNCE_TIME_US = 1000;
  localparam int DEBOUNCE_CYCLES = (CLK_HZ / 1_000_000) * DEBOUNCE_TIME_US;

  // ----------------------------------------------------------------
  // Speed reference
  // ----------------------------------------------------------------
  localparam int SPEED_W = 16;
  localparam int PRESET_COUNT = 4;
  localparam logic [SPEED_W-1:0] SPEED_MAX = 16'hffff;
  localparam logic [SPEED_W-1:0] SPEED_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Modes and states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_TERMINAL = 3'h0,
    SRC_KEYPAD = 3'h1,
    SRC_MODBUS = 3'h2,
    SRC_CANOPEN = 3'h3,
    SRC_MASTER = 3'h4
  } dimc_src_e;

  typedef enum logic [1:0] {
    START_LEVEL_RUN = 2'h0,
    START_LEVEL_FWD_REV = 2'h1,
    START_MOMENTARY = 2'h2
  } dimc_start_e;

  typedef enum logic [2:0] {
    REF_ANALOG_IN1 = 3'h0,
    REF_ANALOG_IN2 = 3'h1,
    REF_PRESET = 3'h2,
    REF_KEYPAD = 3'h3,
    REF_FIELDBUS = 3'h4,
    REF_PI = 3'h5,
    REF_STEP = 3'h6
  } dimc_ref_e;

  typedef enum logic [2:0] {
    AFMT_V0_10 = 3'h0,
    AFMT_MA0_20 = 3'h1,
    AFMT_MA4_20 = 3'h2,
    AFMT_PTC = 3'h3
  } dimc_afmt_e;

  // Gray order along idle, run, fast stop, trip
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_FAST = 2'b11,
    ST_TRIP = 2'b10
  } dimc_state_e;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic stop_nc;
    logic run;
    logic dir_rev;
    logic run_fwd;
    logic run_rev;
    logic start_no;
    logic start_pair_a;
    logic start_pair_b;
    logic start_fwd;
    logic start_rev;
    logic fast_stop_nc;
    logic fast_pair_a;
    logic fast_pair_b;
    logic ext_trip_nc;
    logic fire_mode;
    logic speed_step_up_input;
    logic speed_step_down_input;
    logic [1:0] preset_sel;
  } dimc_term_s;

  typedef struct packed {
    dimc_src_e src;
    dimc_start_e start_mode;
    dimc_ref_e ref_src;
    dimc_afmt_e ain1_fmt;
    dimc_afmt_e ain2_fmt;
    logic keypad_autostart;
    logic pi_feedback_input_from_ain2;
  } dimc_cfg_s;

  typedef struct packed {
    logic [SPEED_W-1:0] analog_in1;
    logic [SPEED_W-1:0] analog_in2;
    logic [SPEED_W-1:0] keypad_speed_reference;
    logic [SPEED_W-1:0] fb_modbus;
    logic [SPEED_W-1:0] fb_canopen;
    logic [SPEED_W-1:0] fb_master;
    logic [SPEED_W-1:0] pi_control_reference;
    logic [PRESET_COUNT-1:0][SPEED_W-1:0] preset_speed_reference;
  } dimc_refs_s;

endpackage

// ==== core/dimc_debounce.sv ====
// Two-stage synchroniser and per-bit debounce filter for terminal inputs
`timescale 1ns/1ps
`default_nettype none

module dimc_debounce #(
  parameter int W = 8,
  parameter int CNT = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] raw,
  output logic [W-1:0] stable
);

  localparam int CW = $clog2(CNT + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(CNT - 1);

  logic [W-1:0] sync1;
  logic [W-1:0] sync2;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= raw;
      sync2 <= sync1;
    end
  end

  // Bounce shorter than CNT cycles never reaches the decoder
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    logic [CW-1:0] cnt;
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        cnt <= '0;
        stable[i] <= 1'b0;
      end
      else if (sync2[i] == stable[i])
        cnt <= '0;
      else if (cnt == CNT_LAST)
      begin
        cnt <= '0;
        stable[i] <= sync2[i];
      end
      else
        cnt <= cnt + 1'b1;
    end
  end

endmodule
`default_nettype wire

// ==== core/dimc_top.sv ====
// Control-terminal input decoding, run state and speed reference selection
`timescale 1ns/1ps
`default_nettype none

module dimc_top #(
  parameter int DEBOUNCE_CYCLES = dimc_pkg::DEBOUNCE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire dimc_pkg::dimc_term_s term_raw,
  input wire dimc_pkg::dimc_cfg_s cfg,
  input wire dimc_pkg::dimc_refs_s refs,
  input wire logic keypad_start,
  input wire logic keypad_stop,
  input wire logic fieldbus_start,
  input wire logic fieldbus_stop,
  input wire logic remote_reverse,
  input wire logic trip_reset,
  output logic run_cmd,
  output logic reverse_cmd,
  output logic fast_stop_cmd,
  output logic trip_active,
  output logic external_trip_indication,
  output logic thermistor_trip_indication,
  output logic fire_mode_active,
  output logic [dimc_pkg::SPEED_W-1:0] speed_ref,
  output logic [dimc_pkg::SPEED_W-1:0] pi_feedback_input,
  output dimc_pkg::dimc_afmt_e ain1_format,
  output dimc_pkg::dimc_afmt_e ain2_format
);

  // ----------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------
  dimc_pkg::dimc_term_s db;
  dimc_pkg::dimc_term_s db_q;
  dimc_pkg::dimc_term_s rise;
  dimc_pkg::dimc_term_s fall;

  dimc_debounce #(
    .W($bits(dimc_pkg::dimc_term_s)),
    .CNT(DEBOUNCE_CYCLES)
  ) u_debounce (
    .clk(clk),
    .rst_n(rst_n),
    .raw(term_raw),
    .stable(db)
  );

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      db_q <= '0;
    else
      db_q <= db;
  end

  assign rise = db & ~db_q;
  assign fall = ~db & db_q;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  wire logic term_mode = (cfg.src == dimc_pkg::SRC_TERMINAL);
  wire logic keypad_mode = (cfg.src == dimc_pkg::SRC_KEYPAD);
  wire logic bus_mode = !term_mode && !keypad_mode;
  wire logic lvl_run = term_mode && (cfg.start_mode == dimc_pkg::START_LEVEL_RUN);
  wire logic lvl_fr = term_mode && (cfg.start_mode == dimc_pkg::START_LEVEL_FWD_REV);
  wire logic mom = term_mode && !lvl_run && !lvl_fr;
  // Stop contact doubles as the hardware enable outside terminal mode
  wire logic enable = db.stop_nc;

  // ----------------------------------------------------------------
  // Events
  // ----------------------------------------------------------------
  // Trip on contact opening
  wire logic trip_ev = fall.ext_trip_nc;
  wire logic fast_pair = db.fast_pair_a && db.fast_pair_b
                         && (rise.fast_pair_a || rise.fast_pair_b);
  wire logic fast_ev = fall.fast_stop_nc || fast_pair;
  wire logic stop_pulse = (keypad_mode && keypad_stop) || (bus_mode && fieldbus_stop);
  // Open stop or any stop event blocks running
  // Stop contact opening falls under the open-stop term
  wire logic block = !db.stop_nc || fast_ev || trip_ev || stop_pulse;

  wire logic pair_start = db.start_pair_a && db.start_pair_b
                          && (rise.start_pair_a || rise.start_pair_b);
  wire logic mom_start = rise.start_no || pair_start || rise.start_fwd || rise.start_rev;
  // Exactly one of forward or reverse closed
  wire logic fr_go = db.run_fwd ^ db.run_rev;
  // Enable alone starts only with autostart set
  wire logic kp_go = enable && (cfg.keypad_autostart || keypad_start);
  // Fieldbus start needs enable already present
  wire logic bus_go = enable && fieldbus_start;

  wire logic level_start = lvl_run || lvl_fr || (keypad_mode && cfg.keypad_autostart);
  wire logic start_req = lvl_run ? db.run :
                         lvl_fr ? fr_go :
                         mom ? mom_start :
                         keypad_mode ? kp_go : bus_go;
  // Level modes keep running only while closed
  wire logic hold = (lvl_run || lvl_fr) ? start_req : 1'b1;

  // ----------------------------------------------------------------
  // Run state
  // ----------------------------------------------------------------
  dimc_pkg::dimc_state_e state;
  dimc_pkg::dimc_state_e next_state;

  // Stop and trip terms checked before start
  always_comb
  begin
    next_state = state;
    case (state)
      dimc_pkg::ST_IDLE:
        if (trip_ev)
          next_state = dimc_pkg::ST_TRIP;
        else if (!block && start_req)
          next_state = dimc_pkg::ST_RUN;
      dimc_pkg::ST_RUN:
        if (trip_ev)
          next_state = dimc_pkg::ST_TRIP;
        else if (fast_ev)
          next_state = dimc_pkg::ST_FAST;
        else if (block || !hold)
          next_state = dimc_pkg::ST_IDLE;
      dimc_pkg::ST_FAST:
        if (trip_ev)
          next_state = dimc_pkg::ST_TRIP;
        else if (level_start)
        begin
          // Level start must be released before another run
          if (!start_req)
            next_state = dimc_pkg::ST_IDLE;
        end
        else if (!block && start_req)
          next_state = dimc_pkg::ST_RUN;
      dimc_pkg::ST_TRIP:
        if (trip_reset && db.ext_trip_nc && !trip_ev)
          next_state = dimc_pkg::ST_IDLE;
      default:
        next_state = dimc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= dimc_pkg::ST_IDLE;
    else
      state <= next_state;
  end

  assign run_cmd = (state == dimc_pkg::ST_RUN);
  assign fast_stop_cmd = (state == dimc_pkg::ST_FAST);
  assign trip_active = (state == dimc_pkg::ST_TRIP);

  // ----------------------------------------------------------------
  // Direction
  // ----------------------------------------------------------------
  logic next_reverse;

  always_comb
  begin
    next_reverse = reverse_cmd;
    if (lvl_run)
      next_reverse = db.dir_rev;
    // Direction from the closed run input
    else if (lvl_fr && fr_go)
      next_reverse = db.run_rev;
    else if (mom && rise.start_rev)
      next_reverse = 1'b1;
    else if (mom && rise.start_fwd)
      next_reverse = 1'b0;
    else if (!term_mode && state != dimc_pkg::ST_RUN && start_req)
      next_reverse = remote_reverse;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reverse_cmd <= 1'b0;
    else
      reverse_cmd <= next_reverse;
  end

  // ----------------------------------------------------------------
  // Trip indication
  // ----------------------------------------------------------------
  logic trip_ptc;
  wire logic ptc_sel = (cfg.ain2_fmt == dimc_pkg::AFMT_PTC);

  // Indication kind caught at the trip edge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      trip_ptc <= 1'b0;
    else if (trip_ev)
      trip_ptc <= ptc_sel;
  end

  assign external_trip_indication = trip_active && !trip_ptc;
  assign thermistor_trip_indication = trip_active && trip_ptc;

  // ----------------------------------------------------------------
  // Speed step reference
  // ----------------------------------------------------------------
  // Saturating step; coincident up and down edges cancel
  function automatic logic [dimc_pkg::SPEED_W-1:0] step_apply(
    input logic [dimc_pkg::SPEED_W-1:0] cur,
    input logic [dimc_pkg::SPEED_W-1:0] step,
    input logic up,
    input logic dn
  );
    logic [dimc_pkg::SPEED_W:0] sum;
    sum = {1'b0, cur} + {1'b0, step};
    if (up && !dn)
      step_apply = sum[dimc_pkg::SPEED_W] ? dimc_pkg::SPEED_MAX : sum[dimc_pkg::SPEED_W-1:0];
    else if (dn && !up)
      step_apply = (cur >= step) ? cur - step : dimc_pkg::SPEED_RESET;
    else
      step_apply = cur;
  endfunction

  logic [dimc_pkg::SPEED_W-1:0] step_ref;
  wire logic [dimc_pkg::SPEED_W-1:0] step_size = refs.preset_speed_reference[0];

  // Step by the first preset on each edge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      step_ref <= dimc_pkg::SPEED_RESET;
    else
      step_ref <= step_apply(step_ref, step_size,
                             rise.speed_step_up_input, rise.speed_step_down_input);
  end

  // ----------------------------------------------------------------
  // Reference selection
  // ----------------------------------------------------------------
  // Preset picked by the two select inputs
  wire logic [dimc_pkg::SPEED_W-1:0] preset_ref = refs.preset_speed_reference[db.preset_sel];
  // Fieldbus source follows the control source
  wire logic [dimc_pkg::SPEED_W-1:0] fieldbus_speed_reference =
    (cfg.src == dimc_pkg::SRC_CANOPEN) ? refs.fb_canopen :
    (cfg.src == dimc_pkg::SRC_MASTER) ? refs.fb_master : refs.fb_modbus;
  logic [dimc_pkg::SPEED_W-1:0] next_speed_ref;

  always_comb
  begin
    case (cfg.ref_src)
      dimc_pkg::REF_ANALOG_IN1: next_speed_ref = refs.analog_in1;
      dimc_pkg::REF_ANALOG_IN2: next_speed_ref = refs.analog_in2;
      dimc_pkg::REF_PRESET: next_speed_ref = preset_ref;
      dimc_pkg::REF_KEYPAD: next_speed_ref = refs.keypad_speed_reference;
      dimc_pkg::REF_FIELDBUS: next_speed_ref = fieldbus_speed_reference;
      dimc_pkg::REF_PI: next_speed_ref = refs.pi_control_reference;
      dimc_pkg::REF_STEP: next_speed_ref = step_ref;
      default: next_speed_ref = dimc_pkg::SPEED_RESET;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      speed_ref <= dimc_pkg::SPEED_RESET;
      pi_feedback_input <= dimc_pkg::SPEED_RESET;
      ain1_format <= dimc_pkg::AFMT_V0_10;
      ain2_format <= dimc_pkg::AFMT_V0_10;
      fire_mode_active <= 1'b0;
    end
    else
    begin
      speed_ref <= next_speed_ref;
      // Feedback from the chosen analog input
      pi_feedback_input <= cfg.pi_feedback_input_from_ain2 ? refs.analog_in2 : refs.analog_in1;
      ain1_format <= cfg.ain1_fmt;
      ain2_format <= cfg.ain2_fmt;
      fire_mode_active <= db.fire_mode;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire logic calm = !fast_ev && !trip_ev;
  // A fast stop or trip right after start may end the run legally
  wire logic run_ok = lvl_run && db.run && db.stop_nc && calm;
  wire logic idle = (state == dimc_pkg::ST_IDLE);

  AST_STOP_OPEN_HALTS: assert property (!db.stop_nc |=> !run_cmd)
    else $error("drive runs with stop contact open");
  AST_RUN_LEVEL: assert property (
    run_ok && idle |=> run_cmd ##1 (run_cmd || !$past(run_ok)))
    else $error("level run did not start or hold");
  AST_DIR_LEVEL: assert property (lvl_run |=> reverse_cmd == $past(db.dir_rev))
    else $error("direction does not follow level input");
  AST_FWD_LEVEL: assert property (
    lvl_fr && db.run_fwd && !db.run_rev && db.stop_nc && idle && calm |=> run_cmd && !reverse_cmd)
    else $error("forward run level failed");
  AST_REV_LEVEL: assert property (
    lvl_fr && db.run_rev && !db.run_fwd && db.stop_nc && idle && calm |=> run_cmd && reverse_cmd)
    else $error("reverse run level failed");
  AST_BUS_ENABLE: assert property (
    bus_mode && idle && !(fieldbus_start && db.stop_nc) |=> !run_cmd)
    else $error("fieldbus start without enable");
  AST_START_EDGE: assert property (
    mom && idle && rise.start_no && db.stop_nc && calm |=> run_cmd)
    else $error("momentary start edge ignored");
  AST_STOP_EDGE: assert property (mom && fall.stop_nc |=> !run_cmd [*2])
    else $error("stop edge did not stop");
  AST_FAST_STOP: assert property (
    state == dimc_pkg::ST_RUN && fall.fast_stop_nc && !trip_ev |=> fast_stop_cmd && !run_cmd)
    else $error("fast stop edge not honoured");
  AST_TRIP: assert property (
    trip_ev |=> trip_active && thermistor_trip_indication == $past(ptc_sel)
    && external_trip_indication == !$past(ptc_sel))
    else $error("trip or its indication wrong");
  AST_STEP_UP: assert property (
    rise.speed_step_up_input && !rise.speed_step_down_input
    && ({1'b0, step_ref} + {1'b0, step_size}) <= {1'b0, dimc_pkg::SPEED_MAX}
    |=> step_ref == $past(step_ref) + $past(step_size))
    else $error("step up amount wrong");
  AST_STEP_DOWN: assert property (
    rise.speed_step_down_input && !rise.speed_step_up_input && step_ref >= step_size
    |=> step_ref == $past(step_ref) - $past(step_size))
    else $error("step down amount wrong");
  AST_STOP_WINS: assert property (start_req && block |=> !run_cmd)
    else $error("start won over a stop");

endmodule
`default_nettype wire

// ==== tb/dimc_contacts.sv ====
// Model of the terminal contacts, with optional chatter
`timescale 1ns/1ps
`default_nettype none

module dimc_contacts (
  input wire logic clk,
  input wire dimc_pkg::dimc_term_s want,
  input wire logic bounce,
  output var dimc_pkg::dimc_term_s term
);
  dimc_pkg::dimc_term_s last = '0;
  dimc_pkg::dimc_term_s diff = '0;
  logic [2:0] cnt = 3'h0;

  // ----------------------------------------------------------------
  // Contact chatter
  // ----------------------------------------------------------------
  // Chatter alternates old and new level, never long enough to pass a filter
  always @(negedge clk)
  begin
    if (want !== last)
    begin
      diff <= want ^ last;
      last <= want;
      cnt <= bounce ? 3'h5 : 3'h0;
    end
    else if (cnt != 3'h0)
    begin
      cnt <= cnt - 3'h1;
    end
  end

  assign term = cnt[0] ? (last ^ diff) : last;
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the drive input macro control block
`timescale 1ns/1ps
`default_nettype none

`define DIMC_CHK(a, e) \
  begin \
    checks++; \
    if ((a) !== (e)) \
    begin \
      fails++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); \
    end \
  end

module tb;
  typedef struct packed {
    logic r, v, f, t, e, h, m;
    logic [15:0] s, p;
    dimc_pkg::dimc_afmt_e a, b;
  } dimc_note_s;

  localparam int LIMIT = 8000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic bn = 1'b0;
  logic thm = 1'b0;
  logic kst = 1'b0, kstp = 1'b0, fst = 1'b0, fstp = 1'b0, rrev = 1'b0, trst = 1'b0;
  logic [15:0] stp = 16'h0000, sd = 16'h4b8f;
  dimc_pkg::dimc_term_s w = '0;
  dimc_pkg::dimc_term_s term;
  dimc_pkg::dimc_cfg_s c = '0;
  dimc_pkg::dimc_refs_s rf = '0;
  logic run_cmd, reverse_cmd, fast_stop_cmd, trip_active, ext_ind, thm_ind, fire;
  logic [15:0] speed_ref, pif;
  dimc_pkg::dimc_afmt_e fmt1, fmt2;
  dimc_note_s q[$];
  dimc_note_s n;
  int fails = 0, checks = 0, cycles = 0;
  event take;
  // Momentary taps: start rev, stop, start fwd, fast stop, start, fast pair,
  // start pair, stop, start together with fast stop
  logic [18:0] mk [9] = '{19'h0_0200, 19'h4_0000, 19'h0_0400, 19'h0_0100,
    19'h0_2000, 19'h0_00c0, 19'h0_1800, 19'h4_0000, 19'h0_2100};
  logic [3:0] ex [9] = '{4'hc, 4'h4, 4'h8, 4'h2, 4'h8, 4'h2, 4'h8, 4'h0, 4'h0};

  always #10 clk = ~clk;

  dimc_contacts contacts_u (.clk(clk), .want(w), .bounce(bn), .term(term));

  dimc_top #(.DEBOUNCE_CYCLES(4)) dut_u (
    .clk(clk), .rst_n(rst_n), .term_raw(term), .cfg(c), .refs(rf),
    .keypad_start(kst), .keypad_stop(kstp), .fieldbus_start(fst), .fieldbus_stop(fstp),
    .remote_reverse(rrev), .trip_reset(trst), .run_cmd(run_cmd),
    .reverse_cmd(reverse_cmd), .fast_stop_cmd(fast_stop_cmd), .trip_active(trip_active),
    .external_trip_indication(ext_ind), .thermistor_trip_indication(thm_ind),
    .fire_mode_active(fire), .speed_ref(speed_ref), .pi_feedback_input(pif),
    .ain1_format(fmt1), .ain2_format(fmt2)
  );

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic logic [15:0] exp_spd();
    case (c.ref_src)
      dimc_pkg::REF_ANALOG_IN1: return rf.analog_in1;
      dimc_pkg::REF_ANALOG_IN2: return rf.analog_in2;
      dimc_pkg::REF_PRESET: return rf.preset_speed_reference[w.preset_sel];
      dimc_pkg::REF_KEYPAD: return rf.keypad_speed_reference;
      dimc_pkg::REF_FIELDBUS: return c.src == dimc_pkg::SRC_CANOPEN ? rf.fb_canopen :
        c.src == dimc_pkg::SRC_MASTER ? rf.fb_master : rf.fb_modbus;
      dimc_pkg::REF_PI: return rf.pi_control_reference;
      dimc_pkg::REF_STEP: return stp;
      default: return 16'h0000;
    endcase
  endfunction

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  // Expected run, reverse, fast, trip in that bit order
  task automatic note(input logic [3:0] o);
    dimc_note_s x;
    x = '{o[3], o[2], o[1], o[0], o[0] & !thm, o[0] & thm, w.fire_mode, exp_spd(),
      c.pi_feedback_input_from_ain2 ? rf.analog_in2 : rf.analog_in1, c.ain1_fmt, c.ain2_fmt};
    q.push_back(x);
    -> take;
  endtask

  task automatic tap(input logic [18:0] k);
    w = w ^ k;
    cyc(20);
    w = w ^ k;
    cyc(20);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(3);
  endtask

  task automatic fill();
    for (int i = 0; i < 11; i++)
    begin
      sd = lfsr(sd);
      rf[i*16 +: 16] = sd;
    end
    rf.preset_speed_reference[0] = 16'h4000;
  endtask

  task automatic print_verdict();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scoreboard and watchdog
  // ----------------------------------------------------------------
  always @(take)
  begin
    n = q.pop_front();
    `DIMC_CHK(run_cmd, n.r)
    `DIMC_CHK(reverse_cmd, n.v)
    `DIMC_CHK(fast_stop_cmd, n.f)
    `DIMC_CHK({trip_active, ext_ind, thm_ind}, {n.t, n.e, n.h})
    `DIMC_CHK(speed_ref, n.s)
    `DIMC_CHK(pif, n.p)
    `DIMC_CHK({fmt1, fmt2}, {n.a, n.b})
    `DIMC_CHK(fire, n.m)
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      fails++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial
  begin
    fill();
    cyc(16);
    rst_n = 1'b1;
    cyc(1);
    note(4'h0);
    w.stop_nc = 1'b1;
    w.fast_stop_nc = 1'b1;
    w.ext_trip_nc = 1'b1;
    bn = 1'b1;
    cyc(20);
    note(4'h0);
    w.run = 1'b1;
    w.dir_rev = 1'b1;
    cyc(20);
    note(4'hc);
    w.stop_nc = 1'b0;
    cyc(20);
    note(4'h4);
    w.run = 1'b0;
    w.dir_rev = 1'b0;
    w.stop_nc = 1'b1;
    cyc(20);
    note(4'h0);
    // short closure must be filtered out
    bn = 1'b0;
    w.run = 1'b1;
    cyc(2);
    w.run = 1'b0;
    cyc(20);
    note(4'h0);
    bn = 1'b1;
    c.start_mode = dimc_pkg::START_LEVEL_FWD_REV;
    w.run_fwd = 1'b1;
    cyc(20);
    note(4'h8);
    w.run_fwd = 1'b0;
    cyc(20);
    note(4'h0);
    w.run_rev = 1'b1;
    cyc(20);
    note(4'hc);
    w.run_rev = 1'b0;
    cyc(20);
    note(4'h4);
    c.start_mode = dimc_pkg::START_MOMENTARY;
    foreach (mk[i])
    begin
      tap(mk[i]);
      note(ex[i]);
    end
    w.stop_nc = 1'b0;
    cyc(20);
    tap(19'h0_2000);
    note(4'h0);
    w.stop_nc = 1'b1;
    cyc(20);
    // Start edge from idle with the stop contact closed
    tap(19'h0_2000);
    note(4'h8);
    for (int i = 0; i < 2; i++)
    begin
      c.ain2_fmt = i ? dimc_pkg::AFMT_PTC : dimc_pkg::AFMT_MA4_20;
      thm = i[0];
      tap(19'h0_0020);
      note(4'h1);
      trst = 1'b1;
      cyc(2);
      trst = 1'b0;
      cyc(2);
      note(4'h0);
    end
    c.src = dimc_pkg::SRC_KEYPAD;
    c.keypad_autostart = 1'b1;
    cyc(3);
    note(4'h8);
    c.keypad_autostart = 1'b0;
    pulse(kstp);
    note(4'h0);
    rrev = 1'b1;
    pulse(kst);
    note(4'hc);
    pulse(kstp);
    note(4'h4);
    // bus start without the enable contact is dropped
    c.src = dimc_pkg::SRC_MODBUS;
    rrev = 1'b0;
    w.stop_nc = 1'b0;
    cyc(20);
    pulse(fst);
    w.stop_nc = 1'b1;
    cyc(20);
    note(4'h4);
    pulse(fst);
    note(4'h8);
    pulse(fstp);
    note(4'h0);
    for (int i = 0; i < 7; i++)
    begin
      fill();
      c.ref_src = dimc_pkg::dimc_ref_e'(i);
      c.ain1_fmt = dimc_pkg::dimc_afmt_e'(i % 4);
      c.pi_feedback_input_from_ain2 = i[0];
      w.fire_mode = i[1];
      cyc(20);
      note(4'h0);
    end
    c.ref_src = dimc_pkg::REF_PRESET;
    for (int i = 0; i < 4; i++)
    begin
      w.preset_sel = i[1:0];
      cyc(20);
      note(4'h0);
    end
    c.ref_src = dimc_pkg::REF_FIELDBUS;
    for (int i = 2; i < 5; i++)
    begin
      c.src = dimc_pkg::dimc_src_e'(i);
      cyc(3);
      note(4'h0);
    end
    // Steps pinned at both ends of the range
    c.ref_src = dimc_pkg::REF_STEP;
    for (int i = 0; i < 8; i++)
    begin
      tap(i < 4 ? 19'h0_0008 : 19'h0_0004);
      if (i < 4)
        stp = stp > 16'hbfff ? 16'hffff : stp + 16'h4000;
      else
        stp = stp < 16'h4000 ? 16'h0000 : stp - 16'h4000;
      note(4'h0);
    end
    cyc(2);
    print_verdict();
  end
endmodule
`default_nettype wire
